// ==== include/swd_pkg.sv ====
package swd_pkg;

  // ==========================================================================
  // Channel count and timing
  // ==========================================================================
  localparam int unsigned NCH            = 4;
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned REPROBE_MS     = 100;
  localparam int unsigned REPROBE_CYCLES = REPROBE_MS * 1000 * CLK_MHZ;
  localparam int unsigned RETRY_US       = 1000;
  localparam int unsigned RETRY_CYCLES   = RETRY_US * CLK_MHZ;
  localparam int unsigned PROBE_US       = 20;
  localparam int unsigned PROBE_CYCLES   = PROBE_US * CLK_MHZ;
  localparam int unsigned CNT_W          = 24;

  typedef logic [CNT_W-1:0] swd_cnt_t;

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_WBCFG  = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_FLAGS  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned CTRL_EN_LSB    = 0;
  localparam int unsigned CTRL_RETRY_BIT = 4;
  localparam int unsigned CTRL_DIAG_BIT  = 5;
  localparam int unsigned WB_REQ_LSB     = 0;
  localparam int unsigned WB_ONDIAG_LSB  = 4;
  localparam int unsigned WB_OFFEN_LSB   = 8;
  localparam int unsigned WB_THD_LSB     = 12;
  localparam int unsigned MASK_THERM     = 0;
  localparam int unsigned MASK_ILIM      = 1;
  localparam int unsigned MASK_WBON      = 2;
  localparam int unsigned MASK_OFF       = 3;
  localparam int unsigned FL_THERM_LSB   = 0;
  localparam int unsigned FL_ILIM_LSB    = 4;
  localparam int unsigned FL_WBON_LSB    = 8;
  localparam int unsigned FL_OFF_LSB     = 12;
  localparam int unsigned ST_OUT_LSB     = 0;
  localparam int unsigned ST_FAULT_BIT   = 4;
  localparam int unsigned ST_SENSE_LSB   = 8;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic       RST_RETRY_DIS = 1'b0;
  localparam logic       RST_DIAG_EN   = 1'b1;
  localparam logic [3:0] RST_MASK      = 4'h0;

  // ==========================================================================
  // Channel states
  // ==========================================================================
  typedef enum logic [2:0] {
    CH_OFF,
    CH_ON,
    CH_CLAMP,
    CH_SHUT,
    CH_LATCHED,
    CH_RECOVER
  } swd_ch_e;

endpackage : swd_pkg

// ==== rtl/swd_diag.sv ====
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
// Contract
// - Listed fault sources drive fault pin unless masked
// - Current limit clamps until thermal shutdown, then off
// - Latched mode holds channel off until enable toggles
// - Auto-retry after fault cleared and retry time
// - After retry, fault held until output near supply
// - Short to ground keeps sense fault asserted
// - On-state probe enables high-resistance path briefly
// - Probe repeats every 100ms while request high
// - Toggling the request starts a new probe
// - Probe needs both enables; open sets flag
// - Three-bit selector sets probe current threshold
// - Pull-up source driven by diagnostic enable
// - Off-state detection only while enable low
// - Off-state open reaches fault pin regardless
// - Off-state sense report needs off-state enable
// - Off-state indication tracks present comparator
// - Off-state indication cleared by disable or enable rise
// - Channels shut down independently of each other
module swd_diag #(
  parameter int unsigned REPROBE_CYCLES = swd_pkg::REPROBE_CYCLES,
  parameter int unsigned RETRY_CYCLES   = swd_pkg::RETRY_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog monitors, one bit per channel
  input  wire logic [3:0]  thermal_fault,
  input  wire logic [3:0]  current_limit_hit,
  input  wire logic [3:0]  out_near_supply,
  input  wire logic [3:0]  offstate_open_threshold,
  input  wire logic [3:0]  onstate_open_detect,
  // Switch and diagnostic controls
  output logic      [3:0]  channel_output,
  output logic      [3:0]  current_clamp,
  output logic      [3:0]  highres_probe,
  output logic      [11:0] onstate_wirebreak_threshold_sel,
  output logic      [3:0]  diag_current_source_enable,
  output logic      [3:0]  sense_enable,
  output logic      [3:0]  sense_out,
  output logic             fault_out_n
);

  // ==========================================================================
  // State
  // ==========================================================================
  localparam swd_pkg::swd_cnt_t PROBE_LEN    = swd_pkg::swd_cnt_t'(swd_pkg::PROBE_CYCLES);
  localparam swd_pkg::swd_cnt_t REPROBE_LAST = swd_pkg::swd_cnt_t'(REPROBE_CYCLES - 1);
  localparam swd_pkg::swd_cnt_t RETRY_LAST   = swd_pkg::swd_cnt_t'(RETRY_CYCLES - 1);

  typedef struct packed {
    logic [3:0]                           en;
    logic [3:0]                           en_prev;
    logic                                 retry_dis;
    logic                                 diag_en;
    logic [3:0]                           wb_req;
    logic [3:0]                           wb_req_prev;
    logic [3:0]                           onstate_wirebreak_request_diag;
    logic [3:0]                           wb_off_en;
    logic [11:0]                          thd;
    logic [3:0]                           mask;
    logic [3:0]                           wbon_flag;
    logic [3:0]                           off_ind;
    swd_pkg::swd_ch_e [3:0]               st;
    logic [3:0][swd_pkg::CNT_W-1:0]       cnt;
    logic [31:0]                          prdata;
    logic                                 pslverr;
  } swd_state_s;

  swd_state_s q;
  swd_state_s d;

  logic       wr_en;
  logic       rd_setup;
  logic       wr_ctrl;
  logic       wr_wbcfg;
  logic       wr_flags;
  logic       addr_ok;
  logic [3:0] f_therm;
  logic [3:0] f_ilim;
  logic [3:0] f_off;
  logic [3:0] en_rise;
  logic [3:0] req_toggle;

  // Counter step: wrap to zero or saturate at the last value
  function automatic swd_pkg::swd_cnt_t cnt_step(input swd_pkg::swd_cnt_t c,
                                                 input swd_pkg::swd_cnt_t last,
                                                 input logic wrap);
    if (c >= last) begin
      cnt_step = wrap ? '0 : last;
    end else begin
      cnt_step = c + swd_pkg::swd_cnt_t'(1);
    end
  endfunction : cnt_step

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  assign pready     = 1'b1;
  assign wr_en      = psel & penable & pwrite;
  assign rd_setup   = psel & ~penable;
  assign wr_ctrl    = wr_en & (paddr == swd_pkg::ADDR_CTRL);
  assign wr_wbcfg   = wr_en & (paddr == swd_pkg::ADDR_WBCFG);
  assign wr_flags   = wr_en & (paddr == swd_pkg::ADDR_FLAGS);
  assign addr_ok    = (paddr == swd_pkg::ADDR_CTRL) | (paddr == swd_pkg::ADDR_WBCFG) |
                      (paddr == swd_pkg::ADDR_MASK) | (paddr == swd_pkg::ADDR_FLAGS) |
                      (paddr == swd_pkg::ADDR_STATUS);
  assign en_rise    = q.en & ~q.en_prev;
  assign req_toggle = q.wb_req ^ q.wb_req_prev;

  // ==========================================================================
  // Per-channel outputs
  // ==========================================================================
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      channel_output[i] = (q.st[i] == swd_pkg::CH_ON) | (q.st[i] == swd_pkg::CH_CLAMP) |
                          (q.st[i] == swd_pkg::CH_RECOVER);
      current_clamp[i]  = (q.st[i] == swd_pkg::CH_CLAMP);
      f_ilim[i]         = current_clamp[i];
      f_therm[i]        = (q.st[i] == swd_pkg::CH_SHUT) | (q.st[i] == swd_pkg::CH_LATCHED) |
                          (q.st[i] == swd_pkg::CH_RECOVER);
      f_off[i]          = q.off_ind[i];
      highres_probe[i]  = (q.st[i] == swd_pkg::CH_ON) & q.onstate_wirebreak_request_diag[i] & q.diag_en &
                          (q.cnt[i] < PROBE_LEN);
      diag_current_source_enable[i] = ~q.en[i] & q.wb_off_en[i] & q.diag_en;
      // Sensing only once the output has risen after a retry
      sense_enable[i]   = (q.st[i] == swd_pkg::CH_ON) | (q.st[i] == swd_pkg::CH_CLAMP);
      sense_out[i]      = f_therm[i] | (q.off_ind[i] & q.wb_off_en[i]);
    end
    onstate_wirebreak_threshold_sel = q.thd;
  end

  // Only unmasked sources pull the pin low
  assign fault_out_n = ~(|(f_therm & {4{~q.mask[swd_pkg::MASK_THERM]}}) |
                         |(f_ilim & {4{~q.mask[swd_pkg::MASK_ILIM]}}) |
                         |(q.wbon_flag & {4{~q.mask[swd_pkg::MASK_WBON]}}) |
                         |(f_off & {4{~q.mask[swd_pkg::MASK_OFF]}}));
  assign prdata  = q.prdata;
  assign pslverr = q.pslverr;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    d             = q;
    d.en_prev     = q.en;
    d.wb_req_prev = q.wb_req;

    if (wr_ctrl) begin
      d.en        = pwdata[swd_pkg::CTRL_EN_LSB +: 4];
      d.retry_dis = pwdata[swd_pkg::CTRL_RETRY_BIT];
      d.diag_en   = pwdata[swd_pkg::CTRL_DIAG_BIT];
    end
    if (wr_wbcfg) begin
      d.wb_req     = pwdata[swd_pkg::WB_REQ_LSB +: 4];
      d.onstate_wirebreak_request_diag = pwdata[swd_pkg::WB_ONDIAG_LSB +: 4];
      d.wb_off_en  = pwdata[swd_pkg::WB_OFFEN_LSB +: 4];
      d.thd        = pwdata[swd_pkg::WB_THD_LSB +: 12];
    end
    if (wr_en && paddr == swd_pkg::ADDR_MASK) begin
      d.mask = pwdata[3:0];
    end

    // A probe hit in the clearing cycle survives the write-one-to-clear
    d.wbon_flag = q.wbon_flag & ~(wr_flags ? pwdata[swd_pkg::FL_WBON_LSB +: 4] : 4'h0);
    d.wbon_flag = d.wbon_flag | (highres_probe & onstate_open_detect);

    for (int i = 0; i < 4; i++) begin
      // Off-state comparator follows the output while disabled
      if (en_rise[i] || (wr_wbcfg && !pwdata[swd_pkg::WB_OFFEN_LSB + i])) begin
        d.off_ind[i] = 1'b0;
      end else if (!q.en[i]) begin
        d.off_ind[i] = offstate_open_threshold[i];
      end else begin
        d.off_ind[i] = 1'b0;
      end

      // Each channel runs its own machine on its own monitors
      case (q.st[i])
        swd_pkg::CH_OFF: begin
          if (q.en[i]) begin
            d.st[i]  = swd_pkg::CH_ON;
            d.cnt[i] = q.wb_req[i] ? '0 : PROBE_LEN;
          end
        end
        swd_pkg::CH_ON: begin
          if (thermal_fault[i]) begin
            d.st[i]  = q.retry_dis ? swd_pkg::CH_LATCHED : swd_pkg::CH_SHUT;
            d.cnt[i] = '0;
          end else if (current_limit_hit[i]) begin
            d.st[i] = swd_pkg::CH_CLAMP;
          end else if (req_toggle[i]) begin
            d.cnt[i] = '0;
          end else if (q.wb_req[i] || q.cnt[i] < PROBE_LEN) begin
            d.cnt[i] = cnt_step(q.cnt[i], REPROBE_LAST, 1'b1);
          end
        end
        swd_pkg::CH_CLAMP: begin
          if (thermal_fault[i]) begin
            d.st[i]  = q.retry_dis ? swd_pkg::CH_LATCHED : swd_pkg::CH_SHUT;
            d.cnt[i] = '0;
          end else if (!current_limit_hit[i]) begin
            d.st[i]  = swd_pkg::CH_ON;
            d.cnt[i] = q.wb_req[i] ? '0 : PROBE_LEN;
          end
        end
        swd_pkg::CH_SHUT: begin
          d.cnt[i] = cnt_step(q.cnt[i], RETRY_LAST, 1'b0);
          if (q.cnt[i] == RETRY_LAST && !thermal_fault[i]) begin
            d.st[i] = swd_pkg::CH_RECOVER;
          end
        end
        swd_pkg::CH_LATCHED: begin
          d.st[i] = swd_pkg::CH_LATCHED;
        end
        swd_pkg::CH_RECOVER: begin
          if (thermal_fault[i]) begin
            d.st[i]  = q.retry_dis ? swd_pkg::CH_LATCHED : swd_pkg::CH_SHUT;
            d.cnt[i] = '0;
          end else if (out_near_supply[i]) begin
            d.st[i]  = swd_pkg::CH_ON;
            d.cnt[i] = q.wb_req[i] ? '0 : PROBE_LEN;
          end
        end
        default: begin
          d.st[i] = swd_pkg::CH_OFF;
        end
      endcase

      // Enable low always wins; it is also what releases a latched channel
      if (!q.en[i]) begin
        d.st[i]  = swd_pkg::CH_OFF;
        d.cnt[i] = '0;
      end
    end

    // Read data captured in the setup cycle, stable through the access
    if (rd_setup) begin
      d.pslverr = ~addr_ok;
      case (paddr)
        swd_pkg::ADDR_CTRL: begin
          d.prdata = {26'h0, q.diag_en, q.retry_dis, q.en};
        end
        swd_pkg::ADDR_WBCFG: begin
          d.prdata = {8'h00, q.thd, q.wb_off_en, q.onstate_wirebreak_request_diag, q.wb_req};
        end
        swd_pkg::ADDR_MASK: begin
          d.prdata = {28'h0, q.mask};
        end
        swd_pkg::ADDR_FLAGS: begin
          d.prdata = {16'h0, f_off, q.wbon_flag, f_ilim, f_therm};
        end
        swd_pkg::ADDR_STATUS: begin
          d.prdata = {20'h0, sense_enable, 3'h0, fault_out_n, channel_output};
        end
        default: begin
          d.prdata = 32'h0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q           <= '0;
      q.retry_dis <= swd_pkg::RST_RETRY_DIS;
      q.diag_en   <= swd_pkg::RST_DIAG_EN;
      q.mask      <= swd_pkg::RST_MASK;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  for (genvar g = 0; g < 4; g++) begin : g_chk
    latched_fault_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
      (q.st[g] == swd_pkg::CH_LATCHED && !q.mask[swd_pkg::MASK_THERM]) |-> !fault_out_n)
      else $error("latched channel without fault pin");

    clamp_then_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      (q.st[g] == swd_pkg::CH_CLAMP && thermal_fault[g] && q.en[g]) |=> !channel_output[g])
      else $error("clamped channel stayed on after thermal shutdown");

    latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (q.st[g] == swd_pkg::CH_LATCHED && q.en[g]) |=> !channel_output[g])
      else $error("latched channel turned on without enable toggle");

    retry_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
      (q.st[g] == swd_pkg::CH_SHUT && q.cnt[g] < RETRY_LAST) |=> !channel_output[g])
      else $error("retry before interval expired");

    recover_sense_a: assert property (@(posedge pclk) disable iff (!presetn)
      (q.st[g] == swd_pkg::CH_RECOVER && !out_near_supply[g] && !thermal_fault[g] && q.en[g])
        |=> (sense_out[g] && !sense_enable[g]))
      else $error("sense fault dropped during grounded retry");

    // A window opened by the counter always starts at count zero
    probe_window_a: assert property (@(posedge pclk) disable iff (!presetn)
      ($rose(highres_probe[g]) && $stable(q.onstate_wirebreak_request_diag[g]) && $stable(q.diag_en)) |-> (q.cnt[g] == '0))
      else $error("probe path opened mid window");

    off_track_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!q.en[g] && !en_rise[g] && !wr_wbcfg) |=> (q.off_ind[g] == $past(offstate_open_threshold[g])))
      else $error("off-state indication not tracking comparator");

    off_sense_a: assert property (@(posedge pclk) disable iff (!presetn)
      (q.off_ind[g] && !q.wb_off_en[g]) |-> (sense_out[g] == f_therm[g]))
      else $error("off-state sense report without enable");

    pullup_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      diag_current_source_enable[g] |=> !channel_output[g])
      else $error("pull-up source active with channel on");
  end

endmodule : swd_diag

// ==== test/swd_host.sv ====
`timescale 1ns/1ps
module swd_host (
  // Bus answer
  input  logic        pclk,
  input  logic        pready,
  input  logic        pslverr,
  input  logic [31:0] prdata,
  // Bus request
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [7:0]  paddr,
  output logic [31:0] pwdata,
  // Transfer never answered
  output logic        hang
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hang = 1'b0;
  end

  // ==========================================================================
  // One transfer; request held until pready is seen at an edge
  // ==========================================================================
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    hang = (n >= 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : swd_host

// ==== test/swd_diag_tb.sv ====
`timescale 1ns/1ps
module swd_diag_tb;
  localparam int RP = 5000;
  localparam int RT = 50;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fault_out_n, e, hang;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, seed;
  logic [3:0]  thermal_fault, current_limit_hit, out_near_supply, offstate_open_threshold, onstate_open_detect;
  logic [3:0]  channel_output, current_clamp, highres_probe, diag_current_source_enable, sense_enable, sense_out;
  logic [11:0] onstate_wirebreak_threshold_sel;
  logic [31:0] mreg [3];
  int          err_total, n_checks, n, hi;

  swd_diag #(.REPROBE_CYCLES(RP), .RETRY_CYCLES(RT)) i_swd_diag (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .thermal_fault, .current_limit_hit, .out_near_supply,
    .offstate_open_threshold, .onstate_open_detect, .channel_output, .current_clamp, .highres_probe,
    .onstate_wirebreak_threshold_sel, .diag_current_source_enable, .sense_enable, .sense_out, .fault_out_n);
  swd_host i_swd_host (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata, .hang);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      $display("Error %s expected %h seen %h", nm, x, g);
      err_total++;
    end
  endtask : chk

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    i_swd_host.xfer(a, w, d, q, e);
    if (hang) begin
      err_total++;
      conclude();
    end
  endtask : bus

  // Model keeps the writable registers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
    if (a < 8'h0c) mreg[a[3:2]] = d;
  endtask : wr

  task automatic rdc(input logic [7:0] a);
    bus(a, 1'b0, 32'h0);
    chk("readback", mreg[a[3:2]], q);
    chk("slverr", 32'h0, e);
  endtask : rdc

  task automatic cyc(input int k);
    repeat (k) @(negedge pclk);
  endtask : cyc

  // Bounded wait for probe level on channel 2, counting cycles
  task automatic waitp(input logic v, output int c);
    c = 0;
    while (highres_probe[2] !== v && c < 3 * RP) begin
      @(negedge pclk);
      c++;
    end
    if (c >= 3 * RP) begin
      err_total++;
      conclude();
    end
  endtask : waitp

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    presetn = 1'b0;
    {thermal_fault, current_limit_hit, out_near_supply} = 12'h0;
    {offstate_open_threshold, onstate_open_detect} = 8'h0;
    err_total = 0;
    n_checks = 0;
    seed = 32'd92724;
    mreg = '{32'h20, 32'h0, 32'h0};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 3; a++) rdc(8'(a * 4));
    bus(8'h14, 1'b0, 32'h0);
    chk("unmapped_err", 32'h1, e);
    chk("unmapped_data", 32'h0, q);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(8'h00, {26'h0, 2'b10, seed[3:0]});
      cyc(3);
      chk("out_follow", mreg[0][3:0], channel_output);
      chk("fault_idle", 32'h1, fault_out_n);
    end
    rdc(8'h00);
    $display("test enable done");
    wr(8'h00, 32'h2f);
    cyc(3);
    @(posedge pclk) current_limit_hit <= 4'h1;
    cyc(3);
    chk("clamp", 32'h1, current_clamp);
    chk("clamp_on", 32'hf, channel_output);
    chk("ilim_pin", 32'h0, fault_out_n);
    wr(8'h08, 32'h2);
    cyc(2);
    chk("ilim_masked", 32'h1, fault_out_n);
    wr(8'h08, 32'h0);
    @(posedge pclk) thermal_fault <= 4'h1;
    cyc(3);
    chk("shut_off", 32'he, channel_output);
    chk("therm_pin", 32'h0, fault_out_n);
    @(posedge pclk) {thermal_fault, current_limit_hit, out_near_supply} <= 12'h00e;
    cyc(RT / 2);
    chk("retry_wait", 32'he, channel_output);
    cyc(RT + 5);
    chk("recover_pin", 32'h0, fault_out_n);
    chk("gnd_sense", 32'h1, sense_out[0]);
    @(posedge pclk) out_near_supply <= 4'hf;
    cyc(3);
    chk("retry_on", 32'hf, channel_output);
    chk("retry_pin", 32'h1, fault_out_n);
    chk("sense_back", 32'h1, sense_enable[0]);
    $display("test retry done");
    wr(8'h00, 32'h3f);
    @(posedge pclk) thermal_fault <= 4'h2;
    @(posedge pclk) thermal_fault <= 4'h0;
    cyc(RT * 3);
    chk("latched", 32'hd, channel_output);
    wr(8'h08, 32'h1);
    cyc(2);
    chk("therm_masked", 32'h1, fault_out_n);
    wr(8'h08, 32'h0);
    bus(8'h0c, 1'b0, 32'h0);
    chk("latch_flag", 32'h2, q[3:0]);
    wr(8'h00, 32'h3d);
    wr(8'h00, 32'h3f);
    cyc(3);
    chk("unlatch", 32'hf, channel_output);
    $display("test latch done");
    for (int c = 0; c < 8; c++) begin
      wr(8'h04, {8'h0, {4{3'(c)}}, 12'h0});
      cyc(2);
      chk("threshold", {4{3'(c)}}, onstate_wirebreak_threshold_sel);
    end
    rdc(8'h04);
    wr(8'h00, 32'h2f);
    wr(8'h04, 32'h44);
    waitp(1'b1, n);
    waitp(1'b0, hi);
    chk("probe_len", 32'h1, {31'h0, hi >= 2497 && hi <= 2503});
    waitp(1'b1, n);
    chk("reprobe", 32'h1, {31'h0, hi + n >= RP - 3 && hi + n <= RP + 3});
    @(posedge pclk) onstate_open_detect <= 4'h4;
    cyc(3);
    bus(8'h0c, 1'b0, 32'h0);
    chk("wb_flag", 32'h1, q[10]);
    chk("wb_pin", 32'h0, fault_out_n);
    wr(8'h08, 32'h4);
    cyc(2);
    chk("wb_masked", 32'h1, fault_out_n);
    wr(8'h08, 32'h0);
    @(posedge pclk) onstate_open_detect <= 4'h0;
    waitp(1'b0, hi);
    wr(8'h0c, 32'h400);
    bus(8'h0c, 1'b0, 32'h0);
    chk("wb_clear", 32'h0, q[10]);
    wr(8'h04, 32'h40);
    wr(8'h04, 32'h44);
    waitp(1'b1, n);
    chk("toggle", 32'h1, {31'h0, n < 8});
    wr(8'h04, 32'h0);
    wr(8'h04, 32'h04);
    cyc(20);
    chk("no_diag", 32'h0, highres_probe[2]);
    wr(8'h00, 32'h0f);
    wr(8'h04, 32'h44);
    cyc(3);
    chk("no_diag_en", 32'h0, highres_probe[2]);
    $display("test probe done");
    wr(8'h00, 32'h27);
    wr(8'h04, 32'h800);
    cyc(2);
    chk("pullup", 32'h8, diag_current_source_enable);
    @(posedge pclk) offstate_open_threshold <= 4'h8;
    cyc(3);
    chk("off_pin", 32'h0, fault_out_n);
    chk("off_sense", 32'h1, sense_out[3]);
    wr(8'h08, 32'h8);
    cyc(2);
    chk("off_masked", 32'h1, fault_out_n);
    wr(8'h08, 32'h0);
    wr(8'h04, 32'h0);
    cyc(3);
    chk("off_nosense", 32'h0, sense_out[3]);
    chk("off_pin_only", 32'h0, fault_out_n);
    chk("pullup_off", 32'h0, diag_current_source_enable);
    wr(8'h04, 32'h800);
    @(posedge pclk) offstate_open_threshold <= 4'h0;
    cyc(3);
    chk("off_track", 32'h1, fault_out_n);
    @(posedge pclk) offstate_open_threshold <= 4'h8;
    cyc(3);
    wr(8'h00, 32'h2f);
    cyc(3);
    chk("en_rise_pin", 32'h1, fault_out_n);
    chk("en_rise_sense", 32'h0, sense_out[3]);
    $display("test offstate done");
    conclude();
  end
endmodule : swd_diag_tb
